/* fbp_defs.svh */
// Constants shared by the bypass-program and status-polling ends.
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
`define FBP_CLK_NS        20
`define FBP_AW            8
`define FBP_DW            16
`define FBP_NWORDS        256
`define FBP_BANK_BIT      7
`define FBP_SEC_HI        7
`define FBP_SEC_LO        5
`define FBP_NSEC          8
`define FBP_SEC_PER_BANK  4
`define FBP_CMD_SETUP     16'h00a0
`define FBP_CMD_EXIT1     16'h0090
`define FBP_CMD_EXIT2     16'h0000
`define FBP_ERASED        16'hffff
`define FBP_POLL_BIT      7
`define FBP_TOG_BIT       6
`define FBP_ESTOG_BIT     2
`define FBP_CW            20
`define FBP_T_PGM_NS      8000
`define FBP_T_ERS_NS      200000
`define FBP_PROTECTED_PROGRAM_POLL_TIME_NS      1000
`define FBP_PROTECTED_PROGRAM_TOGGLE_TIME_NS      1000
`define FBP_ALL_PROTECTED_ERASE_TIME_NS      2000
`define FBP_T_ACT_NS      200
`define FBP_T_CYC_NS      320
`define FBP_T_PGM_CYC     (`FBP_T_PGM_NS / `FBP_CLK_NS)
`define FBP_T_ERS_CYC     (`FBP_T_ERS_NS / `FBP_CLK_NS)
`define FBP_PROTECTED_PROGRAM_POLL_TIME_CYC     (`FBP_PROTECTED_PROGRAM_POLL_TIME_NS / `FBP_CLK_NS)
`define FBP_PROTECTED_PROGRAM_TOGGLE_TIME_CYC     (`FBP_PROTECTED_PROGRAM_TOGGLE_TIME_NS / `FBP_CLK_NS)
`define FBP_ALL_PROTECTED_ERASE_TIME_CYC     (`FBP_ALL_PROTECTED_ERASE_TIME_NS / `FBP_CLK_NS)
`define FBP_T_ACT_CYC     (`FBP_T_ACT_NS / `FBP_CLK_NS)
`define FBP_T_CYC_CYC     (`FBP_T_CYC_NS / `FBP_CLK_NS)
`endif

/* fbp_pkg.sv */
// Types shared by the bypass-program and status-polling ends.
package fbp_pkg;
  typedef enum logic [2:0] {ST_READ, ST_PGM, ST_PROT_PGM, ST_ERS, ST_PROT_ERS,
                            ST_ERS_SUSP} fbp_dev_st_t;
  typedef enum logic [1:0] {CMD_IDLE, CMD_SETUP, CMD_EXIT} fbp_cmd_st_t;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_PGM, OP_EXIT} fbp_op_t;
  typedef enum logic [3:0] {H_IDLE, H_SETUP, H_DATA, H_POLL_A, H_POLL_B, H_FINAL,
                            H_EXIT1, H_EXIT2, H_WRITE, H_READ} fbp_host_st_t;
endpackage : fbp_pkg

/* fbp_bus_if.sv */
// Asynchronous parallel flash bus joining the host end and the device end.
`include "fbp_defs.svh"
interface fbp_bus_if;
  logic                ce_n;
  logic                oe_n;
  logic                we_n;
  logic [`FBP_AW-1:0]  addr;
  logic [`FBP_DW-1:0]  host_dq;
  logic                host_dq_oe_n;
  logic [`FBP_DW-1:0]  dev_dq;
  logic                dev_dq_oe_n;
  logic [`FBP_DW-1:0]  dq;

  // Resolved data wire; an undriven bus floats high through its pull-ups.
  assign dq = !dev_dq_oe_n ? dev_dq : (!host_dq_oe_n ? host_dq : `FBP_ERASED);

  modport host (output ce_n, output oe_n, output we_n, output addr, output host_dq,
                output host_dq_oe_n, input dq);
  modport dev  (input ce_n, input oe_n, input we_n, input addr, output dev_dq,
                output dev_dq_oe_n, input dq);
endinterface : fbp_bus_if

/* fbp_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
module fbp_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;

  // Only the second stage is ever read by other logic.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule // fbp_sync

/* fbp_device.sv */
// Device end: bypass program/exit decoding and write-operation status reads.
`include "fbp_defs.svh"
module fbp_device
  import fbp_pkg::*;
#(
  parameter int unsigned T_ERS_CYC = `FBP_T_ERS_CYC
) (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  fbp_bus_if.dev                   bus,
  input  wire logic                bypass_enter,
  input  wire logic                erase_start,
  input  wire logic [`FBP_NSEC-1:0] erase_sel,
  input  wire logic                erase_suspend,
  input  wire logic                erase_resume,
  input  wire logic [`FBP_NSEC-1:0] sector_prot,
  output logic                     bypass_mode_ff,
  output logic                     busy_ff,
  output logic                     erase_susp_ff
);
  localparam int unsigned CW = `FBP_CW;
  localparam int unsigned SPB = `FBP_SEC_PER_BANK;
  localparam int unsigned PROT_PGM_MAX =
    (`FBP_PROTECTED_PROGRAM_POLL_TIME_CYC > `FBP_PROTECTED_PROGRAM_TOGGLE_TIME_CYC) ? `FBP_PROTECTED_PROGRAM_POLL_TIME_CYC : `FBP_PROTECTED_PROGRAM_TOGGLE_TIME_CYC;
  localparam logic [CW-1:0] PGM_END  = CW'(`FBP_T_PGM_CYC - 1);
  localparam logic [CW-1:0] PPGM_END = CW'(PROT_PGM_MAX - 1);
  localparam logic [CW-1:0] PAP_LIM  = CW'(`FBP_PROTECTED_PROGRAM_TOGGLE_TIME_CYC);
  localparam logic [CW-1:0] ASP_END  = CW'(`FBP_ALL_PROTECTED_ERASE_TIME_CYC - 1);
  localparam logic [CW-1:0] ERS_END  = CW'(T_ERS_CYC - 1);

  logic               ce_n_s, oe_n_s, we_n_s;
  logic [`FBP_AW-1:0] addr_s;
  logic [`FBP_DW-1:0] dq_s;
  logic               rd_act_ff, wr_act_ff;
  fbp_dev_st_t        st_ff, nxt_st;
  fbp_cmd_st_t        cmd_ff, nxt_cmd;
  logic               nxt_bypass;
  logic [CW-1:0]      op_cnt_ff, ers_cnt_ff;
  logic [`FBP_AW-1:0] pgm_addr_ff;
  logic [`FBP_DW-1:0] pgm_data_ff;
  logic               erase_pend_ff;
  logic [`FBP_NSEC-1:0] erase_sel_ff, erase_do_ff;
  logic [1:0]         tog6_ff;
  logic               tog2_ff;
  logic [`FBP_DW-1:0] mem_ff [`FBP_NWORDS];
  logic [`FBP_DW-1:0] dq_ff;
  logic               dq_oe_n_ff;
  logic [`FBP_DW-1:0] status_word;

  // Every bus pin is asynchronous to sys_clk, so all of them pass two flops.
  fbp_sync #(
    .W       (3 + `FBP_AW + `FBP_DW),
    .RST_VAL ({3'h7, {(`FBP_AW + `FBP_DW){1'b0}}})
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       ({bus.ce_n, bus.oe_n, bus.we_n, bus.addr, bus.dq}),
    .q       ({ce_n_s, oe_n_s, we_n_s, addr_s, dq_s})
  );

  // Access edges: a write ends and a read ends when the strobe pair releases.
  wire rd_act  = !ce_n_s && !oe_n_s;
  wire wr_act  = !ce_n_s && !we_n_s;
  wire wr_edge = wr_act_ff && !wr_act;
  wire rd_end  = rd_act_ff && !rd_act;

  // Address decode for the current access.
  wire                rd_bank   = addr_s[`FBP_BANK_BIT];
  wire [2:0]          rd_sec    = addr_s[`FBP_SEC_HI:`FBP_SEC_LO];
  wire                sel_sec   = erase_sel_ff[rd_sec];
  wire                bank_sel  = |erase_sel_ff[rd_bank*SPB +: SPB];
  wire                pgm_phase = (st_ff == ST_PGM) || (st_ff == ST_PROT_PGM);
  wire                ers_run   = (st_ff == ST_ERS) || (st_ff == ST_PROT_ERS);
  wire                pgm_bank  = pgm_addr_ff[`FBP_BANK_BIT] == rd_bank;
  wire                busy_rb   = pgm_phase ? pgm_bank : (ers_run && bank_sel);
  wire                tog6_en   = busy_rb && !(st_ff == ST_PROT_PGM && op_cnt_ff >= PAP_LIM);
  wire                tog2_en   = sel_sec && (ers_run || st_ff == ST_ERS_SUSP);
  wire                susp_sel  = (st_ff == ST_ERS_SUSP) && sel_sec && !pgm_phase;
  wire                show_stat = busy_rb || susp_sel;
  wire [2:0]          pa_sec    = addr_s[`FBP_SEC_HI:`FBP_SEC_LO];
  wire                pgm_ok    = (st_ff == ST_READ) || (st_ff == ST_ERS_SUSP);
  wire                pgm_go    = wr_edge && bypass_mode_ff && cmd_ff == CMD_SETUP && pgm_ok;
  wire                all_prot  = (erase_sel & ~sector_prot) == '0;

  // Poll bit by phase: inverted datum while programming, low while erasing,
  // high while suspended. A buffered page would only poll its last word.
  wire poll_bit = pgm_phase ? ~pgm_data_ff[`FBP_POLL_BIT] : (st_ff == ST_ERS_SUSP);

  // Status word; the bits outside this block's scope read as zero.
  always_comb
  begin
    status_word                 = '0;
    status_word[`FBP_POLL_BIT]  = poll_bit;
    status_word[`FBP_TOG_BIT]   = tog6_ff[rd_bank];
    status_word[`FBP_ESTOG_BIT] = tog2_ff;
  end

  // Bypass command decoder; only the setup and exit cycles are known here.
  always_comb
  begin
    nxt_cmd    = cmd_ff;
    nxt_bypass = bypass_mode_ff | bypass_enter;
    if (wr_edge && bypass_mode_ff)
    begin
      unique case (cmd_ff)
        CMD_IDLE:
        begin
          if (dq_s == `FBP_CMD_SETUP) nxt_cmd = CMD_SETUP;
          else if (dq_s == `FBP_CMD_EXIT1) nxt_cmd = CMD_EXIT;
        end
        CMD_SETUP: nxt_cmd = CMD_IDLE;
        CMD_EXIT:
        begin
          nxt_cmd = CMD_IDLE;
          if (dq_s == `FBP_CMD_EXIT2) nxt_bypass = 1'b0;
        end
      endcase
    end
  end

  // Operation sequencer; the phase changes on the final write edge itself.
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_READ:
      begin
        if (erase_start) nxt_st = all_prot ? ST_PROT_ERS : ST_ERS;
        else if (pgm_go) nxt_st = sector_prot[pa_sec] ? ST_PROT_PGM : ST_PGM;
      end
      ST_PGM:
        if (op_cnt_ff >= PGM_END) nxt_st = erase_pend_ff ? ST_ERS_SUSP : ST_READ;
      ST_PROT_PGM:
        if (op_cnt_ff >= PPGM_END) nxt_st = erase_pend_ff ? ST_ERS_SUSP : ST_READ;
      ST_ERS:
      begin
        if (erase_suspend) nxt_st = ST_ERS_SUSP;
        else if (ers_cnt_ff >= ERS_END) nxt_st = ST_READ;
      end
      ST_PROT_ERS:
        if (ers_cnt_ff >= ASP_END) nxt_st = ST_READ;
      ST_ERS_SUSP:
      begin
        if (erase_resume) nxt_st = ST_ERS;
        else if (pgm_go) nxt_st = sector_prot[pa_sec] ? ST_PROT_PGM : ST_PGM;
      end
      default: nxt_st = ST_READ;
    endcase
  end

  // Phase, command and strobe-edge state.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff          <= ST_READ;
      cmd_ff         <= CMD_IDLE;
      bypass_mode_ff <= 1'b0;
      rd_act_ff      <= 1'b0;
      wr_act_ff      <= 1'b0;
      busy_ff        <= 1'b0;
      erase_susp_ff  <= 1'b0;
    end
    else
    begin
      st_ff          <= nxt_st;
      cmd_ff         <= nxt_cmd;
      bypass_mode_ff <= nxt_bypass;
      rd_act_ff      <= rd_act;
      wr_act_ff      <= wr_act;
      busy_ff        <= (nxt_st != ST_READ) && (nxt_st != ST_ERS_SUSP);
      erase_susp_ff  <= nxt_st == ST_ERS_SUSP;
    end
  end

  // Timers; the erase timer holds while suspended so resume continues it.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      op_cnt_ff  <= '0;
      ers_cnt_ff <= '0;
    end
    else
    begin
      op_cnt_ff  <= pgm_go ? '0 : (pgm_phase ? op_cnt_ff + 1'b1 : op_cnt_ff);
      ers_cnt_ff <= (st_ff == ST_READ && erase_start) ? '0 :
                    (ers_run ? ers_cnt_ff + 1'b1 : ers_cnt_ff);
    end
  end

  // Operation operands captured when the operation is accepted.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pgm_addr_ff   <= '0;
      pgm_data_ff   <= '0;
      erase_pend_ff <= 1'b0;
      erase_sel_ff  <= '0;
      erase_do_ff   <= '0;
    end
    else
    begin
      if (pgm_go)
      begin
        pgm_addr_ff   <= addr_s;
        pgm_data_ff   <= dq_s;
        erase_pend_ff <= st_ff == ST_ERS_SUSP;
      end
      if (st_ff == ST_READ && erase_start)
      begin
        erase_sel_ff <= erase_sel;
        erase_do_ff  <= erase_sel & ~sector_prot;
      end
      else if (ers_run && nxt_st == ST_READ)
      begin
        erase_sel_ff <= '0;
        erase_do_ff  <= '0;
      end
    end
  end

  // Toggle flops advance only at the end of a qualifying read, so a single
  // long read never sees the bit move.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tog6_ff <= '0;
      tog2_ff <= 1'b0;
    end
    else if (rd_end)
    begin
      if (tog6_en) tog6_ff[rd_bank] <= ~tog6_ff[rd_bank];
      if (tog2_en) tog2_ff <= ~tog2_ff;
    end
  end

  // Array: protected programs never write; erase fills whole sectors.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < `FBP_NWORDS; i++) mem_ff[i] <= `FBP_ERASED;
    end
    else if (st_ff == ST_PGM && nxt_st != ST_PGM)
      mem_ff[pgm_addr_ff] <= mem_ff[pgm_addr_ff] & pgm_data_ff;
    else if (st_ff == ST_ERS && nxt_st == ST_READ)
    begin
      for (int i = 0; i < `FBP_NWORDS; i++)
        if (erase_do_ff[i >> `FBP_SEC_LO]) mem_ff[i] <= `FBP_ERASED;
    end
  end

  // Read data is re-evaluated every cycle; the poll bit may therefore lead
  // the other bits at completion, which the host resolves by re-reading.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      dq_ff      <= '0;
      dq_oe_n_ff <= 1'b1;
    end
    else
    begin
      dq_ff      <= show_stat ? status_word : mem_ff[addr_s];
      dq_oe_n_ff <= !rd_act;
    end
  end

  assign bus.dev_dq      = dq_ff;
  assign bus.dev_dq_oe_n = dq_oe_n_ff;
endmodule // fbp_device

/* fbp_host.sv */
// Host end: issues bypass program and exit sequences and polls for completion.
`include "fbp_defs.svh"
module fbp_host
  import fbp_pkg::*;
(
  input  wire logic               sys_clk,
  input  wire logic               rst,
  fbp_bus_if.host                 bus,
  input  wire logic               req_valid,
  input  wire fbp_op_t            req_op,
  input  wire logic [`FBP_AW-1:0] req_addr,
  input  wire logic [`FBP_DW-1:0] req_data,
  output logic                    busy_ff,
  output logic                    done_ff,
  output logic [`FBP_DW-1:0]      rdata_ff
);
  localparam logic [4:0] ACT_END = 5'(`FBP_T_ACT_CYC - 1);
  localparam logic [4:0] CYC_END = 5'(`FBP_T_CYC_CYC - 1);

  fbp_host_st_t       st_ff, nxt_st;
  logic [4:0]         cnt_ff;
  logic [`FBP_AW-1:0] addr_ff;
  logic [`FBP_DW-1:0] data_ff, smp_ff, dq_s, wdata;
  logic               tog_ff;
  logic               ce_n_ff, oe_n_ff, we_n_ff, dq_oe_n_ff;
  logic [`FBP_DW-1:0] dq_out_ff;

  // Returned data is asynchronous to sys_clk.
  fbp_sync #(.W(`FBP_DW), .RST_VAL('0)) u_dq_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d       (bus.dq),
    .q       (dq_s)
  );

  // Cycle decode; every access holds its address and data to the cycle end.
  wire idle    = st_ff == H_IDLE;
  wire is_wr   = (st_ff == H_SETUP) || (st_ff == H_DATA) || (st_ff == H_EXIT1) ||
                 (st_ff == H_EXIT2) || (st_ff == H_WRITE);
  wire active  = !idle && cnt_ff <= ACT_END;
  wire smp_now = !idle && !is_wr && cnt_ff == ACT_END;
  wire cyc_end = !idle && cnt_ff == CYC_END;
  wire smp_tog = dq_s[`FBP_TOG_BIT];

  // Write data per step: setup value, program data, or the two exit values.
  always_comb
  begin
    unique case (st_ff)
      H_SETUP: wdata = `FBP_CMD_SETUP;
      H_EXIT1: wdata = `FBP_CMD_EXIT1;
      H_EXIT2: wdata = `FBP_CMD_EXIT2;
      default: wdata = data_ff;
    endcase
  end

  // Step sequencer. Polling repeats until two successive toggle samples agree,
  // then one more read returns clean data.
  always_comb
  begin
    nxt_st = st_ff;
    if (idle && req_valid)
    begin
      unique case (req_op)
        OP_PGM:   nxt_st = H_SETUP;
        OP_EXIT:  nxt_st = H_EXIT1;
        OP_WRITE: nxt_st = H_WRITE;
        OP_READ:  nxt_st = H_READ;
      endcase
    end
    else if (cyc_end)
    begin
      unique case (st_ff)
        H_SETUP:  nxt_st = H_DATA;
        H_DATA:   nxt_st = H_POLL_A;
        H_POLL_A: nxt_st = H_POLL_B;
        H_POLL_B: nxt_st = (smp_ff[`FBP_TOG_BIT] == tog_ff) ? H_FINAL : H_POLL_B;
        H_EXIT1:  nxt_st = H_EXIT2;
        default:  nxt_st = H_IDLE;
      endcase
    end
  end

  // Sequencer state and captured request.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff   <= H_IDLE;
      cnt_ff  <= '0;
      addr_ff <= '0;
      data_ff <= '0;
    end
    else
    begin
      st_ff  <= nxt_st;
      cnt_ff <= (idle || cyc_end) ? '0 : cnt_ff + 1'b1;
      if (idle && req_valid)
      begin
        addr_ff <= req_addr;
        data_ff <= req_data;
      end
    end
  end

  // Samples; the previous toggle value is kept for the next comparison.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      smp_ff <= '0;
      tog_ff <= 1'b0;
    end
    else if (smp_now)
    begin
      smp_ff <= dq_s;
      tog_ff <= smp_ff[`FBP_TOG_BIT];
    end
  end

  // Pins. Reads release both strobes before the next access so every
  // toggle is observed.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ce_n_ff    <= 1'b1;
      oe_n_ff    <= 1'b1;
      we_n_ff    <= 1'b1;
      dq_oe_n_ff <= 1'b1;
      dq_out_ff  <= '0;
    end
    else
    begin
      ce_n_ff    <= !active;
      oe_n_ff    <= !(active && !is_wr);
      we_n_ff    <= !(active && is_wr);
      dq_oe_n_ff <= !is_wr;
      dq_out_ff  <= wdata;
    end
  end

  // User-side answer; the final extra read gives fully valid data.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      busy_ff <= nxt_st != H_IDLE;
      done_ff <= cyc_end && nxt_st == H_IDLE;
      if (cyc_end && (st_ff == H_FINAL || st_ff == H_READ)) rdata_ff <= smp_ff;
    end
  end

  assign bus.ce_n         = ce_n_ff;
  assign bus.oe_n         = oe_n_ff;
  assign bus.we_n         = we_n_ff;
  assign bus.addr         = addr_ff;
  assign bus.host_dq      = dq_out_ff;
  assign bus.host_dq_oe_n = dq_oe_n_ff;
endmodule // fbp_host

/* fbp_bus_sva.sv */
// Bus checker that watches the link between the host end and the device end.
`include "fbp_defs.svh"
module fbp_bus_sva (
  input wire logic               sys_clk,
  input wire logic               rst,
  input wire logic               ce_n,
  input wire logic               oe_n,
  input wire logic               we_n,
  input wire logic [`FBP_AW-1:0] addr,
  input wire logic [`FBP_DW-1:0] host_dq,
  input wire logic               host_dq_oe_n,
  input wire logic               dev_dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Both ends driving the data wire at once would corrupt every status word.
  property p_no_contend;
    dev_dq_oe_n || host_dq_oe_n;
  endproperty
  // The device only turns its drivers on inside a selected read.
  property p_dev_on_read;
    $fell(dev_dq_oe_n) |-> !oe_n && !ce_n && we_n;
  endproperty
  // Once the read strobe ends the device lets go of the wire promptly.
  property p_dev_release;
    $rose(oe_n) |-> ##[1:8] dev_dq_oe_n;
  endproperty
  // Read and write strobes are separate accesses, so the toggle can advance.
  property p_strobe_excl;
    oe_n || we_n;
  endproperty
  property p_ce_qual;
    (!oe_n || !we_n) |-> !ce_n;
  endproperty
  // Address and data stay put for the whole write strobe.
  property p_wr_hold;
    (!we_n && !$past(we_n)) |-> $stable(addr) && $stable(host_dq) && !host_dq_oe_n;
  endproperty
  property p_we_len;
    $fell(we_n) |-> (!we_n)[*8] ##[1:3] we_n;
  endproperty
  // A setup write is always followed by the data write of the same program.
  property p_setup_next;
    ($rose(we_n) && host_dq == `FBP_CMD_SETUP) |-> ##[10:40] $rose(we_n);
  endproperty
  property p_exit_pair;
    ($rose(we_n) && host_dq == `FBP_CMD_EXIT1)
      |-> ##[10:40] ($rose(we_n) && host_dq == `FBP_CMD_EXIT2);
  endproperty

  a_no_contend: assert property (p_no_contend)
    else $error("both ends drive the data wire");
  a_dev_on_read: assert property (p_dev_on_read)
    else $error("device drives outside a read");
  a_dev_release: assert property (p_dev_release)
    else $error("device holds the wire after the read");
  a_strobe_excl: assert property (p_strobe_excl)
    else $error("read and write strobes overlap");
  a_ce_qual: assert property (p_ce_qual)
    else $error("strobe without chip enable");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write address or data moved");
  a_we_len: assert property (p_we_len)
    else $error("write strobe length wrong");
  a_setup_next: assert property (p_setup_next)
    else $error("setup write not followed by data write");
  a_exit_pair: assert property (p_exit_pair)
    else $error("exit sequence second write missing");

  c_setup: cover property ($rose(we_n) && host_dq == `FBP_CMD_SETUP);
  c_exit: cover property ($rose(we_n) && host_dq == `FBP_CMD_EXIT2);
  c_dev_read: cover property ($fell(dev_dq_oe_n));
endmodule // fbp_bus_sva

/* testbench.sv */
// Self-checking bench joining the host end and the device end.
`include "fbp_defs.svh"
module testbench
  import fbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [15:0] val;
    logic [15:0] mask;
    bit          rel;
    string       name;
  } fbp_note_t;
  logic           sys_clk, rst, req_valid, h_busy, h_done, d_bypass, d_busy, d_susp;
  logic           bypass_enter, erase_start, erase_suspend, erase_resume;
  fbp_op_t        req_op;
  logic [7:0]     req_addr, erase_sel, sector_prot, a;
  logic [15:0]    req_data, h_rdata, last_rd, d;
  logic [15:0]    mem [256];
  fbp_note_t      note_q [$];
  int             error_cnt, samples_checked, i;

  fbp_bus_if u_fbp_bus_if ();
  fbp_host u_fbp_host (.sys_clk(sys_clk), .rst(rst), .bus(u_fbp_bus_if), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_data(req_data), .busy_ff(h_busy),
    .done_ff(h_done), .rdata_ff(h_rdata));
  fbp_device #(.T_ERS_CYC(2000)) u_fbp_device (.sys_clk(sys_clk), .rst(rst),
    .bus(u_fbp_bus_if), .bypass_enter(bypass_enter), .erase_start(erase_start),
    .erase_sel(erase_sel), .erase_suspend(erase_suspend), .erase_resume(erase_resume),
    .sector_prot(sector_prot), .bypass_mode_ff(d_bypass), .busy_ff(d_busy),
    .erase_susp_ff(d_susp));
  fbp_bus_sva u_fbp_bus_sva (.sys_clk(sys_clk), .rst(rst), .ce_n(u_fbp_bus_if.ce_n),
    .oe_n(u_fbp_bus_if.oe_n), .we_n(u_fbp_bus_if.we_n), .addr(u_fbp_bus_if.addr),
    .host_dq(u_fbp_bus_if.host_dq), .host_dq_oe_n(u_fbp_bus_if.host_dq_oe_n),
    .dev_dq_oe_n(u_fbp_bus_if.dev_dq_oe_n));

  // Clock of 50 MHz.
  always #10 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic cmp_word(string nm, logic [15:0] e, logic [15:0] s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic cmp_flag(string nm, logic e, logic s);
    samples_checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask

  // Relative notes compare against the previous read so toggles need no absolute phase.
  always @(negedge sys_clk)
    if (h_done === 1'b1)
    begin
      if (note_q.size() == 0)
        cmp_word("unexpected_done", 16'h0000, 16'hffff);
      else if (note_q[0].mask != 16'h0000)
      begin
        cmp_word(note_q[0].name, (note_q[0].rel ? last_rd ^ note_q[0].val : note_q[0].val)
                 & note_q[0].mask, h_rdata & note_q[0].mask);
        last_rd = h_rdata;
      end
      if (note_q.size() != 0)
        void'(note_q.pop_front());
    end

  // One host request; the expected result is noted before it is issued.
  task automatic host_op(fbp_op_t op, logic [7:0] ad, logic [15:0] dt, logic [15:0] ev,
                         logic [15:0] em, bit rel, string nm);
    int n;
    note_q.push_back('{ev, em, rel, nm});
    req_op = op;
    req_addr = ad;
    req_data = dt;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    cmp_flag("host_busy", 1'b1, h_busy);
    for (n = 0; n < 3000 && h_done !== 1'b1; n++)
      @(negedge sys_clk);
    if (n >= 3000)
    begin
      cmp_flag("host_done", 1'b1, h_done);
      test_done();
    end
    @(negedge sys_clk);
  endtask

  task automatic pgm(logic [7:0] ad, logic [15:0] dt);
    if (!sector_prot[ad[7:5]])
      mem[ad] = mem[ad] & dt;
    host_op(OP_PGM, ad, dt, mem[ad], 16'hffff, 0, "pgm_final");
  endtask

  task automatic wait_idle();
    int n;
    for (n = 0; n < 5000 && d_busy !== 1'b0; n++)
      @(negedge sys_clk);
    cmp_flag("dev_busy", 1'b0, d_busy);
    // A device that never goes idle ends the run here rather than hanging.
    if (n >= 5000)
      test_done();
  endtask

  // Main sequence; all inputs move on the falling edge.
  initial
  begin
    sys_clk = 0;
    rst = 1;
    {req_valid, bypass_enter, erase_start, erase_suspend, erase_resume} = '0;
    req_op = OP_READ;
    {req_addr, req_data, erase_sel} = '0;
    sector_prot = 8'h40;
    foreach (mem[k]) mem[k] = 16'hffff;
    void'($urandom(34));
    repeat (8) @(negedge sys_clk);
    rst = 0;
    @(negedge sys_clk);
    cmp_flag("bypass_reset", 1'b0, d_bypass);
    bypass_enter = 1;
    @(negedge sys_clk);
    bypass_enter = 0;
    repeat (4) @(negedge sys_clk);
    cmp_flag("bypass_on", 1'b1, d_bypass);
    for (i = 0; i < 4; i++)
    begin
      a = {1'b0, ($urandom % 2) ? 2'b10 : 2'b00, 5'($urandom)};
      d = 16'($urandom);
      pgm(a, d);
      host_op(OP_READ, a, 16'h0000, mem[a], 16'hffff, 0, "pgm_readback");
    end
    pgm({3'b110, 5'($urandom)}, 16'h0000);
    // Erase sector 1 in bank 0; bank 1 keeps returning array data.
    erase_sel = 8'h02;
    erase_start = 1;
    @(negedge sys_clk);
    erase_start = 0;
    host_op(OP_READ, 8'hc5, 16'h0000, 16'hffff, 16'hffff, 0, "other_bank");
    host_op(OP_READ, 8'h27, 16'h0000, 16'h0000, 16'hff80, 0, "erase_poll");
    host_op(OP_READ, 8'h27, 16'h0000, 16'h0044, 16'h0044, 1, "erase_toggles");
    host_op(OP_READ, 8'h03, 16'h0000, 16'h0040, 16'h0040, 1, "bank_toggle");
    host_op(OP_READ, 8'h03, 16'h0000, 16'h0040, 16'h0044, 1, "unsel_no_t2");
    erase_suspend = 1;
    @(negedge sys_clk);
    erase_suspend = 0;
    repeat (8) @(negedge sys_clk);
    cmp_flag("suspended", 1'b1, d_susp);
    host_op(OP_READ, 8'h31, 16'h0000, 16'h0080, 16'hff80, 0, "susp_poll");
    host_op(OP_READ, 8'h31, 16'h0000, 16'h0004, 16'h0044, 1, "susp_toggle");
    host_op(OP_READ, a, 16'h0000, mem[a], 16'hffff, 0, "susp_array");
    pgm(8'h11, 16'($urandom));
    erase_resume = 1;
    @(negedge sys_clk);
    erase_resume = 0;
    wait_idle();
    host_op(OP_READ, 8'h31, 16'h0000, 16'hffff, 16'hffff, 0, "erased");
    host_op(OP_READ, 8'h31, 16'h0000, 16'hffff, 16'hffff, 0, "toggle_stop");
    // Every selected sector protected: brief status, then array data.
    erase_sel = 8'h40;
    erase_start = 1;
    @(negedge sys_clk);
    erase_start = 0;
    host_op(OP_READ, 8'hc9, 16'h0000, 16'h0000, 16'hff80, 0, "prot_erase");
    wait_idle();
    host_op(OP_READ, 8'hc9, 16'h0000, 16'hffff, 16'hffff, 0, "prot_erase_end");
    host_op(OP_EXIT, 8'h00, 16'h0000, 16'h0000, 16'h0000, 0, "exit");
    cmp_flag("bypass_off", 1'b0, d_bypass);
    // Outside bypass mode a raw setup and data pair must not program the word.
    host_op(OP_WRITE, 8'h44, `FBP_CMD_SETUP, 16'h0000, 16'h0000, 0, "raw_setup");
    host_op(OP_WRITE, 8'h44, 16'h0000, 16'h0000, 16'h0000, 0, "raw_data");
    host_op(OP_READ, 8'h44, 16'h0000, mem[8'h44], 16'hffff, 0, "no_bypass_pgm");
    cmp_flag("still_idle", 1'b0, d_busy);
    test_done();
  end
endmodule // testbench
